// ===== verilog/clc_pkg.sv
// Constants and types shared by the character display instruction core
package clc_pkg;

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned NIB_W         = 4;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned FIFO_W        = 16;
  localparam int unsigned FIFO_DEPTH    = 4;

  // Core clock period and instruction execution times, in ns
  localparam int unsigned CORE_PERIOD_NS = 8;
  localparam int unsigned LONG_TIME_NS   = 1530000;
  localparam int unsigned SHORT_TIME_NS  = 39000;

  // Least times, rounded up to whole cycles
  localparam int unsigned LONG_CYCLES  = (LONG_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned SHORT_CYCLES = (SHORT_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // Command byte fields
  localparam int unsigned BIT_CLEAR     = 0;
  localparam int unsigned BIT_HOME      = 1;
  localparam int unsigned BIT_ENTRY     = 2;
  localparam int unsigned BIT_STEP      = 1;
  localparam int unsigned BIT_SCROLL    = 0;
  localparam int unsigned FOREIGN_LO    = 3;
  localparam int unsigned BUSY_BIT      = 7;

  localparam logic [7:0] SPACE_CODE     = 8'h20;
  localparam logic [6:0] HOME_ADDR      = 7'h00;
  localparam logic [6:0] ADDR_STEP      = 7'h01;
  localparam logic [6:0] GLYPH_MASK     = 7'h3F;
  localparam logic [6:0] LAST_TEXT_ADDR = 7'h4F;
  localparam logic [4:0] FOREIGN_NONE   = 5'h00;
  localparam logic [2:0] CLEAR_CODE     = 3'h1;
  localparam logic [3:0] NIB_ZERO       = 4'h0;

  // Reset values of the entry mode settings
  localparam logic       STEP_INC_RST   = 1'b1;
  localparam logic       SCROLL_RST     = 1'b0;

  typedef enum logic [0:0] {
    FILL_IDLE,
    FILL_RUN
  } clc_fill_type;

endpackage : clc_pkg

// ===== verilog/clc_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module clc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IDX_W:0]   CNT_FULL = (IDX_W+1)'(DEPTH);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [IDX_W-1:0] wr_idx_r;
  logic [IDX_W-1:0] rd_idx_r;
  logic [IDX_W:0]   count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != CNT_FULL);
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_idx_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_r[wr_idx_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_idx_r <= (wr_idx_r == IDX_LAST) ? '0 : wr_idx_r + 1'b1;
      end
      if (pop)
      begin
        rd_idx_r <= (rd_idx_r == IDX_LAST) ? '0 : rd_idx_r + 1'b1;
      end
      if (push & ~pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : clc_fifo

// ===== verilog/clc_busy_timer.sv
// Execution countdown that holds busy while an instruction runs
`timescale 1ns/1ps
module clc_busy_timer (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     start,
  input  wire logic [clc_pkg::CNT_W-1:0] load_cycles,
  output logic                          busy
);

  logic [clc_pkg::CNT_W-1:0] count_r;

  assign busy = (count_r != '0);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_r <= '0;
    end
    else if (start)
    begin
      count_r <= load_cycles;
    end
    else if (busy)
    begin
      count_r <= count_r - 1'b1;
    end
  end

endmodule : clc_busy_timer

// ===== verilog/clc_instruction_core.sv
// Instruction front end: host strobe port, command decode, address pointer
`timescale 1ns/1ps
module clc_instruction_core #(
  parameter int unsigned LONG_CYCLES  = clc_pkg::LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = clc_pkg::SHORT_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       strobe,
  input  wire logic       target_select,
  input  wire logic       read_not_write,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            data_oe,
  input  wire logic       bus_4bit,
  input  wire logic       glyph_select,
  input  wire logic       addr_load,
  input  wire logic [6:0] addr_load_value,
  input  wire logic [7:0] ram_rd_data,
  output logic            ram_rd_pulse,
  output logic            ram_wr_valid,
  input  wire logic       ram_wr_ready,
  output logic [7:0]      ram_wr_data,
  output logic [6:0]      ram_wr_addr,
  output logic            ram_wr_glyph,
  output logic            busy_indicator,
  output logic [6:0]      address_pointer,
  output logic            step_inc,
  output logic            auto_scroll,
  output logic            shift_pulse,
  output logic            shift_left,
  output logic            home_pulse
);

  // Pointer step, masked to the smaller glyph space when needed
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc, input logic glyph);
    logic [6:0] n;
    n = inc ? a + clc_pkg::ADDR_STEP : a - clc_pkg::ADDR_STEP;
    step_addr = glyph ? (n & clc_pkg::GLYPH_MASK) : n;
  endfunction : step_addr

  logic                  strobe_r;
  logic                  sel_r;
  logic                  dir_r;
  logic                  nib_low_r;
  logic [3:0]            hi_nib_r;
  logic                  fall;
  logic                  xfer_done;
  logic [7:0]            xfer_byte;
  logic [7:0]            command_latch_r;
  logic [7:0]            data_latch_r;
  logic                  cmd_go_r;
  logic                  data_go_r;
  logic                  rd_go_r;
  logic                  is_ours;
  logic                  do_entry;
  logic                  do_home;
  logic                  do_clear;
  logic [6:0]            ptr_r;
  logic                  step_inc_r;
  logic                  auto_scroll_r;
  logic                  shift_pulse_r;
  logic                  shift_left_r;
  logic                  home_pulse_r;
  logic                  ram_rd_pulse_r;
  clc_pkg::clc_fill_type fill_state_r;
  logic [6:0]            fill_idx_r;
  logic                  fill_active;
  logic                  push_valid;
  logic                  push_ready;
  logic [15:0]           push_data;
  logic [15:0]           pop_data;
  logic                  data_accept;
  logic                  timer_start;
  logic [clc_pkg::CNT_W-1:0] timer_load;
  logic                  timer_busy;
  logic [7:0]            rd_byte;
  logic [7:0]            data_out_r;
  logic                  data_oe_r;

  // Host port: strobe taken on its falling edge, select and direction while high
  assign fall = strobe_r & ~strobe;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      strobe_r <= 1'b0;
      sel_r    <= 1'b0;
      dir_r    <= 1'b0;
    end
    else
    begin
      strobe_r <= strobe;
      if (strobe)
      begin
        sel_r <= target_select;
        dir_r <= read_not_write;
      end
    end
  end

  // Nibble pairing in four-bit mode
  always_ff @(posedge core_clk)
  begin
    if (rst | ~bus_4bit)
    begin
      nib_low_r <= 1'b0;
      hi_nib_r  <= clc_pkg::NIB_ZERO;
    end
    else if (fall)
    begin
      nib_low_r <= ~nib_low_r;
      if (~nib_low_r)
      begin
        hi_nib_r <= data_in[7:4];
      end
    end
  end

  assign xfer_done = fall & (~bus_4bit | nib_low_r);
  assign xfer_byte = bus_4bit ? {hi_nib_r, data_in[7:4]} : data_in;

  // Capture into the two latches; work starts on the next internal edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      command_latch_r <= '0;
      data_latch_r    <= '0;
      cmd_go_r        <= 1'b0;
      data_go_r       <= 1'b0;
      rd_go_r         <= 1'b0;
    end
    else
    begin
      cmd_go_r  <= xfer_done & ~sel_r & ~dir_r;
      data_go_r <= xfer_done & sel_r & ~dir_r;
      rd_go_r   <= xfer_done & sel_r & dir_r;
      if (xfer_done & ~sel_r & ~dir_r)
      begin
        command_latch_r <= xfer_byte;
      end
      if (xfer_done & sel_r & ~dir_r)
      begin
        data_latch_r <= xfer_byte;
      end
    end
  end

  // Only clear, return home and entry mode are handled here
  assign is_ours  = (command_latch_r[7:clc_pkg::FOREIGN_LO] == clc_pkg::FOREIGN_NONE);
  assign do_entry = cmd_go_r & is_ours & command_latch_r[clc_pkg::BIT_ENTRY];
  assign do_home  = cmd_go_r & is_ours & ~command_latch_r[clc_pkg::BIT_ENTRY]
                    & command_latch_r[clc_pkg::BIT_HOME];
  assign do_clear = cmd_go_r & is_ours & (command_latch_r[2:0] == clc_pkg::CLEAR_CODE);

  // Data writes are dropped if the buffer is full; busy already warned the host
  assign data_accept = data_go_r & ~fill_active & push_ready;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ptr_r <= clc_pkg::HOME_ADDR;
    end
    else if (do_clear | do_home)
    begin
      ptr_r <= clc_pkg::HOME_ADDR;
    end
    else if (addr_load)
    begin
      ptr_r <= addr_load_value;
    end
    else if (data_accept | rd_go_r)
    begin
      ptr_r <= step_addr(ptr_r, step_inc_r, glyph_select);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      step_inc_r    <= clc_pkg::STEP_INC_RST;
      auto_scroll_r <= clc_pkg::SCROLL_RST;
    end
    else if (do_clear)
    begin
      step_inc_r <= 1'b1;
    end
    else if (do_entry)
    begin
      step_inc_r    <= command_latch_r[clc_pkg::BIT_STEP];
      auto_scroll_r <= command_latch_r[clc_pkg::BIT_SCROLL];
    end
  end

  // Whole-display shift on text writes only, direction from the step setting
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      shift_pulse_r  <= 1'b0;
      shift_left_r   <= 1'b0;
      home_pulse_r   <= 1'b0;
      ram_rd_pulse_r <= 1'b0;
    end
    else
    begin
      shift_pulse_r  <= data_accept & auto_scroll_r & ~glyph_select;
      shift_left_r   <= step_inc_r;
      home_pulse_r   <= do_home | do_clear;
      ram_rd_pulse_r <= rd_go_r;
    end
  end

  // Clear fills all text locations through the write buffer
  assign fill_active = (fill_state_r == clc_pkg::FILL_RUN);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fill_state_r <= clc_pkg::FILL_IDLE;
      fill_idx_r   <= clc_pkg::HOME_ADDR;
    end
    else
    begin
      unique case (fill_state_r)
        clc_pkg::FILL_IDLE:
        begin
          if (do_clear)
          begin
            fill_state_r <= clc_pkg::FILL_RUN;
            fill_idx_r   <= clc_pkg::HOME_ADDR;
          end
        end
        clc_pkg::FILL_RUN:
        begin
          if (push_ready)
          begin
            fill_idx_r <= step_addr(fill_idx_r, 1'b1, 1'b0);
            if (fill_idx_r == clc_pkg::LAST_TEXT_ADDR)
            begin
              fill_state_r <= clc_pkg::FILL_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign push_valid = fill_active | data_go_r;
  assign push_data  = fill_active ? {1'b0, fill_idx_r, clc_pkg::SPACE_CODE}
                                  : {glyph_select, ptr_r, data_latch_r};

  clc_fifo #(
    .WIDTH (clc_pkg::FIFO_W),
    .DEPTH (clc_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (ram_wr_valid),
    .out_ready (ram_wr_ready),
    .out_data  (pop_data)
  );

  assign ram_wr_glyph = pop_data[15];
  assign ram_wr_addr  = pop_data[14:8];
  assign ram_wr_data  = pop_data[7:0];

  // Clear and home get the long countdown; entry mode, accepted data writes and data reads the short one
  assign timer_start = do_entry | do_home | do_clear | data_accept | rd_go_r;
  assign timer_load  = (do_home | do_clear) ? clc_pkg::CNT_W'(LONG_CYCLES)
                                            : clc_pkg::CNT_W'(SHORT_CYCLES);

  clc_busy_timer u_busy_timer (
    .core_clk    (core_clk),
    .rst         (rst),
    .start       (timer_start),
    .load_cycles (timer_load),
    .busy        (timer_busy)
  );

  // Busy from the latching strobe until the countdown, the fill and a full buffer all end
  assign busy_indicator = cmd_go_r | data_go_r | rd_go_r | timer_busy
                          | fill_active | ~push_ready;

  // Read path: status byte or RAM byte, nibble-split in four-bit mode
  assign rd_byte = target_select ? ram_rd_data
                                 : {busy_indicator, ptr_r};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      data_out_r <= '0;
      data_oe_r  <= 1'b0;
    end
    else
    begin
      data_oe_r <= strobe & read_not_write;
      if (strobe & read_not_write)
      begin
        if (~bus_4bit)
        begin
          data_out_r <= rd_byte;
        end
        else if (nib_low_r)
        begin
          data_out_r <= {rd_byte[3:0], clc_pkg::NIB_ZERO};
        end
        else
        begin
          data_out_r <= {rd_byte[7:4], clc_pkg::NIB_ZERO};
        end
      end
    end
  end

  assign data_out        = data_out_r;
  assign data_oe         = data_oe_r;
  assign address_pointer = ptr_r;
  assign step_inc        = step_inc_r;
  assign auto_scroll     = auto_scroll_r;
  assign shift_pulse     = shift_pulse_r;
  assign shift_left      = shift_left_r;
  assign home_pulse      = home_pulse_r;
  assign ram_rd_pulse    = ram_rd_pulse_r;

endmodule : clc_instruction_core

// ===== test/clc_instruction_core_properties.sv
// Port-level assertion checker for the instruction core
`timescale 1ns/1ps
module clc_instruction_core_properties #(
  parameter int unsigned LONG_CYCLES  = 40,
  parameter int unsigned SHORT_CYCLES = 8
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       strobe,
  input wire logic       target_select,
  input wire logic       read_not_write,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       bus_4bit,
  input wire logic       glyph_select,
  input wire logic       addr_load,
  input wire logic       busy_indicator,
  input wire logic [6:0] address_pointer,
  input wire logic       step_inc,
  input wire logic       auto_scroll,
  input wire logic       shift_pulse,
  input wire logic       shift_left,
  input wire logic       ram_rd_pulse,
  input wire logic       home_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_cmd_fall;
    (strobe && !read_not_write && !target_select && !bus_4bit) ##1 !strobe;
  endsequence
  sequence s_rd_fall;
    (strobe && read_not_write && target_select && !bus_4bit) ##1 !strobe;
  endsequence
  property p_rd_pulse;
    s_rd_fall |=> ##1 ram_rd_pulse;
  endproperty
  property p_clear;
    s_cmd_fall ##0 (data_in == 8'h01) |=> ##1 (home_pulse && step_inc && address_pointer == 7'h00);
  endproperty
  property p_entry;
    s_cmd_fall ##0 (data_in[7:2] == 6'h01) |=> ##1
      (step_inc == $past(data_in[1], 2) && auto_scroll == $past(data_in[0], 2));
  endproperty
  property p_busy_start;
    s_cmd_fall ##0 (data_in[7:3] == 5'h00 && data_in != 8'h00) |=> busy_indicator [*4];
  endproperty
  // Clear with a stalling sink is the longest case
  property p_busy_end;
    $rose(busy_indicator) |-> ##[1:600] !busy_indicator;
  endproperty
  property p_status;
    strobe && read_not_write && !target_select && !bus_4bit |=>
      data_oe && data_out == {$past(busy_indicator), $past(address_pointer)};
  endproperty
  property p_no_drive;
    !$past(strobe && read_not_write) |-> !data_oe;
  endproperty
  property p_home;
    home_pulse |-> address_pointer == 7'h00;
  endproperty
  property p_shift;
    shift_pulse |-> $past(auto_scroll) && shift_left == $past(step_inc);
  endproperty
  property p_step;
    (address_pointer != $past(address_pointer)) && !home_pulse && !$past(addr_load) && !$past(glyph_select)
      |-> address_pointer == $past(address_pointer) + ($past(step_inc) ? 7'h01 : 7'h7F);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not home and force increment");
  a_entry: assert property (p_entry) else $error("entry mode bits not taken");
  a_busy_start: assert property (p_busy_start) else $error("busy not held after command");
  a_busy_end: assert property (p_busy_end) else $error("busy never cleared");
  a_status: assert property (p_status) else $error("status read mismatch");
  a_no_drive: assert property (p_no_drive) else $error("data driven without read");
  a_home: assert property (p_home) else $error("home pulse with nonzero pointer");
  a_shift: assert property (p_shift) else $error("shift without scroll or wrong side");
  a_step: assert property (p_step) else $error("pointer step not one");
  a_rd_pulse: assert property (p_rd_pulse) else $error("no RAM read pulse after data read");
endmodule : clc_instruction_core_properties

// ===== test/clc_ram_sink.sv
// Behavioural display and glyph RAM behind the write stream
`timescale 1ns/1ps
module clc_ram_sink (
  input  wire logic       core_clk,
  input  wire logic       hold,
  input  wire logic       slow,
  input  wire logic       ram_wr_valid,
  output logic            ram_wr_ready,
  input  wire logic [7:0] ram_wr_data,
  input  wire logic [6:0] ram_wr_addr,
  input  wire logic       ram_wr_glyph,
  input  wire logic       glyph_select,
  input  wire logic [6:0] address_pointer,
  output logic [7:0]      ram_rd_data
);
  logic [7:0] text_mem [128];
  logic [7:0] glyph_mem [64];
  logic       tgl_r;
  initial
  begin
    tgl_r = 1'b0;
    foreach (text_mem[i])
      text_mem[i] = 8'hEE;
    foreach (glyph_mem[i])
      glyph_mem[i] = 8'hEE;
  end
  // Slow mode drops ready every other cycle to stretch the stream
  assign ram_wr_ready = !hold && !(slow && tgl_r);
  assign ram_rd_data  = glyph_select ? glyph_mem[address_pointer[5:0]] : text_mem[address_pointer];
  always @(posedge core_clk)
  begin
    tgl_r <= !tgl_r;
    if (ram_wr_valid && ram_wr_ready && ram_wr_glyph)
      glyph_mem[ram_wr_addr[5:0]] <= ram_wr_data;
    else if (ram_wr_valid && ram_wr_ready)
      text_mem[ram_wr_addr] <= ram_wr_data;
  end
endmodule : clc_ram_sink

// ===== test/test_clc_instruction_core.sv
// Self-checking bench for the instruction core
`timescale 1ns/1ps
module test_clc_instruction_core;
  localparam int unsigned LONG_CYCLES  = 40;
  localparam int unsigned SHORT_CYCLES = 8;
  logic       core_clk;
  logic       rst;
  logic       strobe;
  logic       target_select;
  logic       read_not_write;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       bus_4bit;
  logic       glyph_select;
  logic       addr_load;
  logic [6:0] addr_load_value;
  logic [7:0] ram_rd_data;
  logic       ram_wr_valid;
  logic       ram_wr_ready;
  logic [7:0] ram_wr_data;
  logic [6:0] ram_wr_addr;
  logic       ram_wr_glyph;
  logic       busy_indicator;
  logic [6:0] address_pointer;
  logic       step_inc;
  logic       auto_scroll;
  logic       shift_pulse;
  logic       shift_left;
  logic       home_pulse;
  logic       ram_rd_pulse;
  logic       hold;
  logic       slow;
  logic       last_left;
  logic [7:0] s;
  int         miscompares;
  int         n_compared;
  int         shifts;
  int         homes;
  int         cycles;
  int         rd_pulses;

  clc_instruction_core #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) clc_instruction_core_inst (
    .core_clk(core_clk), .rst(rst), .strobe(strobe), .target_select(target_select),
    .read_not_write(read_not_write), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .bus_4bit(bus_4bit), .glyph_select(glyph_select), .addr_load(addr_load), .addr_load_value(addr_load_value),
    .ram_rd_data(ram_rd_data), .ram_rd_pulse(ram_rd_pulse), .ram_wr_valid(ram_wr_valid),
    .ram_wr_ready(ram_wr_ready),
    .ram_wr_data(ram_wr_data), .ram_wr_addr(ram_wr_addr), .ram_wr_glyph(ram_wr_glyph),
    .busy_indicator(busy_indicator), .address_pointer(address_pointer), .step_inc(step_inc),
    .auto_scroll(auto_scroll), .shift_pulse(shift_pulse), .shift_left(shift_left), .home_pulse(home_pulse));

  clc_ram_sink clc_ram_sink_inst (
    .core_clk(core_clk), .hold(hold), .slow(slow), .ram_wr_valid(ram_wr_valid), .ram_wr_ready(ram_wr_ready),
    .ram_wr_data(ram_wr_data), .ram_wr_addr(ram_wr_addr), .ram_wr_glyph(ram_wr_glyph),
    .glyph_select(glyph_select), .address_pointer(address_pointer), .ram_rd_data(ram_rd_data));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (shift_pulse)
      shifts++;
    if (shift_pulse)
      last_left = shift_left;
    if (home_pulse)
      homes++;
    if (ram_rd_pulse)
      rd_pulses++;
    if (cycles == 20000)
      miscompares++;
    if (cycles == 20000)
      print_verdict();
  end

  task automatic print_verdict();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  // One strobe: high for a cycle, then low while data is sampled
  task automatic strb(input logic sel, input logic rnw, input logic [7:0] d, output logic [7:0] r);
    @(negedge core_clk);
    strobe = 1'b1;
    target_select = sel;
    read_not_write = rnw;
    data_in = d;
    @(negedge core_clk);
    r = data_out;
    strobe = 1'b0;
    @(negedge core_clk);
  endtask : strb

  task automatic wr(input logic sel, input logic [7:0] b);
    logic [7:0] r;
    if (bus_4bit)
      strb(sel, 1'b0, {b[7:4], 4'h0}, r);
    strb(sel, 1'b0, bus_4bit ? {b[3:0], 4'h0} : b, r);
  endtask : wr

  task automatic rd(input logic sel, output logic [7:0] b);
    logic [7:0] h;
    logic [7:0] l;
    if (bus_4bit)
    begin
      strb(sel, 1'b1, 8'h00, h);
      strb(sel, 1'b1, 8'h00, l);
      b = {h[7:4], l[7:4]};
    end
    else
      strb(sel, 1'b1, 8'h00, b);
  endtask : rd

  // Poll busy, wait for the write buffer to drain, then one spare cycle before the next strobe
  task automatic idle();
    logic [7:0] r;
    r = 8'h80;
    for (int i = 0; i < 300 && r[7]; i++)
      rd(1'b0, r);
    for (int i = 0; i < 50 && ram_wr_valid; i++)
      @(negedge core_clk);
    @(negedge core_clk);
  endtask : idle

  task automatic op(input logic sel, input logic [7:0] b);
    wr(sel, b);
    idle();
  endtask : op

  task automatic ld(input logic [6:0] a);
    @(negedge core_clk);
    addr_load = 1'b1;
    addr_load_value = a;
    @(negedge core_clk);
    addr_load = 1'b0;
  endtask : ld

  initial
  begin
    {rst, strobe, target_select, read_not_write, data_in, bus_4bit, glyph_select} = {1'b1, 13'h0000};
    {addr_load, addr_load_value, hold, slow, last_left} = 11'h000;
    {miscompares, n_compared, shifts, homes, cycles, rd_pulses} = '0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    rd(1'b0, s);
    chk8(s, 8'h00);
    chk8({6'h00, step_inc, auto_scroll}, 8'h02);
    op(1'b0, 8'h04);
    slow = 1'b1;
    wr(1'b0, 8'h01);
    rd(1'b0, s);
    chk8({7'h00, s[7]}, 8'h01);
    idle();
    for (int i = 0; i < 80; i++)
      chk8(clc_ram_sink_inst.text_mem[i], 8'h20);
    rd(1'b0, s);
    chk8(s, 8'h00);
    chk8({7'h00, step_inc}, 8'h01);
    slow = 1'b0;
    op(1'b0, 8'h06);
    op(1'b1, 8'h41);
    op(1'b1, 8'h42);
    chk8(clc_ram_sink_inst.text_mem[1], 8'h42);
    rd(1'b0, s);
    chk8(s, 8'h02);
    op(1'b0, 8'h04);
    op(1'b1, 8'h43);
    chk8(clc_ram_sink_inst.text_mem[2], 8'h43);
    rd(1'b0, s);
    chk8(s, 8'h01);
    op(1'b0, 8'h07);
    op(1'b1, 8'h44);
    chk8({shifts[6:0], last_left}, 8'h03);
    op(1'b0, 8'h05);
    op(1'b1, 8'h45);
    chk8({shifts[6:0], last_left}, 8'h04);
    op(1'b0, 8'h02);
    rd(1'b0, s);
    chk8(s, 8'h00);
    chk8(clc_ram_sink_inst.text_mem[0], 8'h41);
    ld(7'h05);
    op(1'b0, 8'h03);
    rd(1'b0, s);
    chk8({s[6:0], homes[0]}, 8'h01);
    op(1'b0, 8'h06);
    rd(1'b1, s);
    idle();
    chk8(s, 8'h41);
    op(1'b0, 8'h07);
    glyph_select = 1'b1;
    ld(7'h05);
    op(1'b1, 8'h1F);
    chk8(clc_ram_sink_inst.glyph_mem[5], 8'h1F);
    ld(7'h05);
    rd(1'b1, s);
    idle();
    chk8(s, 8'h1F);
    rd(1'b0, s);
    chk8(s, 8'h06);
    glyph_select = 1'b0;
    ld(7'h00);
    rd(1'b1, s);
    idle();
    chk8(s, 8'h41);
    chk8(shifts[7:0], 8'h02);
    op(1'b0, 8'h06);
    hold = 1'b1;
    ld(7'h0A);
    for (int i = 0; i < 3; i++)
      op(1'b1, 8'h50 + 8'(i));
    wr(1'b1, 8'h53);
    repeat (20) @(negedge core_clk);
    rd(1'b0, s);
    chk8({7'h00, s[7]}, 8'h01);
    hold = 1'b0;
    idle();
    for (int i = 0; i < 4; i++)
      chk8(clc_ram_sink_inst.text_mem[10 + i], 8'h50 + 8'(i));
    bus_4bit = 1'b1;
    op(1'b1, 8'h5A);
    chk8(clc_ram_sink_inst.text_mem[14], 8'h5A);
    rd(1'b0, s);
    chk8(s, 8'h0F);
    bus_4bit = 1'b0;
    wr(1'b0, 8'h80);
    rd(1'b0, s);
    chk8(s, 8'h0F);
    chk8(rd_pulses[7:0], 8'h03);
    print_verdict();
  end
endmodule : test_clc_instruction_core

bind clc_instruction_core clc_instruction_core_properties #(
  .LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) clc_props_inst (
  .core_clk(core_clk), .rst(rst), .strobe(strobe), .target_select(target_select),
  .read_not_write(read_not_write), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .bus_4bit(bus_4bit), .glyph_select(glyph_select), .addr_load(addr_load), .busy_indicator(busy_indicator),
  .address_pointer(address_pointer), .step_inc(step_inc), .auto_scroll(auto_scroll),
  .shift_pulse(shift_pulse), .shift_left(shift_left), .ram_rd_pulse(ram_rd_pulse), .home_pulse(home_pulse));
